// file: dv/srb_ctrl_model.sv
/* Memory controller model: link clocks, commands and write data, one frame per call.
   Assumes i_mclk is much faster than the link; a half link period is four i_mclk cycles. */
`timescale 1ns/10ps
`default_nettype none
// ****************
// Controller model
// ****************
module srb_ctrl_model (
  // Clock and read-back
  input  wire logic        i_mclk,
  input  wire logic [35:0] i_q,
  input  wire logic        i_oe,
  // Link clocks and command
  output logic             o_kt,
  output logic             o_kn,
  output logic             o_ct,
  output logic             o_cn,
  output logic             o_ld_n,
  output logic             o_rnw,
  output logic [5:0]       o_addr,
  // Write side
  output logic [3:0]       o_bwe_n,
  output logic [35:0]      o_d
);
  logic [35:0] rq [0:6];
  logic        roe [0:6];
  logic [35:0] p_q;
  logic        p_oe;
  initial begin
    {o_kt, o_kn, o_ct, o_cn, o_ld_n, o_rnw} = 6'h02;
    o_addr = 6'h00;
    o_bwe_n = 4'hf;
    o_d = 36'h0;
  end
  // Clocks run only inside a frame; six halves, then the input clocks rest low.
  task automatic frame(input logic ld, input logic rd, input logic [5:0] a,
                       input logic [143:0] w, input logic [15:0] en,
                       input logic chi, input int pause);
    for (int h = 0; h < 7; h++) begin
      if (h == pause) begin
        {o_kt, o_kn, o_ct, o_cn, o_ld_n} <= 5'h00;
        repeat (20) @(posedge i_mclk);
        p_q = i_q;
        p_oe = i_oe;
      end
      o_kt <= h < 6 && h % 2 == 0;
      o_kn <= h < 6 && h % 2 == 1;
      o_ct <= chi || (h < 6 && h % 2 == 0);
      o_cn <= chi || (h < 6 && h % 2 == 1);
      o_ld_n <= !(ld && h == 0);
      o_rnw <= rd;
      o_addr <= a;
      o_bwe_n <= (h < 4) ? en[h*4 +: 4] : 4'hf;
      // A released bus toggles each half between the last word and its inverse.
      o_d <= (!rd && h < 4) ? w[h*36 +: 36] : ~o_d;
      repeat (2) @(posedge i_mclk);
      rq[h] = i_q;
      roe[h] = i_oe;
      repeat (2) @(posedge i_mclk);
    end
  endtask
endmodule // srb_ctrl_model
`default_nettype wire

// file: dv/srb_sram_core_asserts.sv
/* Port checker for the burst SRAM core.
   Assumes link pins change on i_mclk rises and reach the outputs within five edges. */
`timescale 1ns/10ps
`default_nettype none
// ****************
// Port checks
// ****************
module srb_sram_core_asserts #(parameter DW = 18) (
  // Clock and reset
  input wire          i_mclk,
  input wire          i_rst,
  // Link
  input wire          i_clk_in_true,
  input wire          i_clk_in_inv,
  input wire          i_clk_out_true,
  input wire          i_clk_out_inv,
  input wire          i_load_strobe_n,
  input wire          i_read_not_write,
  // Data out
  input wire [DW-1:0] o_dq,
  input wire          o_dq_oe
);
  reg       kt_q, kn_q, ct_q, cn_q, rd_pend;
  reg [2:0] n_lr;
  reg [3:0] n_stop;
  wire      chi = i_clk_out_true & i_clk_out_inv;
  wire      lr = chi ? (i_clk_in_true & ~kt_q | i_clk_in_inv & ~kn_q)
                     : (i_clk_out_true & ~ct_q | i_clk_out_inv & ~cn_q);
  wire      moved = {i_clk_in_true, i_clk_in_inv, i_clk_out_true, i_clk_out_inv}
                    != {kt_q, kn_q, ct_q, cn_q};
  // Launch rises are counted only while the bus is driven, so the load edge never counts.
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      {kt_q, kn_q, ct_q, cn_q, rd_pend} <= 5'h00;
      n_lr <= 3'h0;
      n_stop <= 4'h0;
    end else begin
      {kt_q, kn_q, ct_q, cn_q} <= {i_clk_in_true, i_clk_in_inv, i_clk_out_true, i_clk_out_inv};
      rd_pend <= (rd_pend | i_clk_in_true & ~kt_q & ~i_load_strobe_n & i_read_not_write)
                 & ~o_dq_oe;
      n_lr <= o_dq_oe ? n_lr + {2'h0, lr} : 3'h0;
      n_stop <= moved ? 4'h0 : n_stop + {3'h0, n_stop != 4'hf};
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  property p_rel_idle; $fell(i_rst) |-> !o_dq_oe && o_dq == '0; endproperty
  a_rel_idle: assert property (p_rel_idle) else $error("Bus driven after reset");
  property p_stop_hold; n_stop > 4'h5 |-> $stable(o_dq) && $stable(o_dq_oe); endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("Output moved, clocks stopped");
  property p_launch; !$stable(o_dq) || !$stable(o_dq_oe) |-> $past(lr, 3) || $past(lr, 4) || $past(lr, 5); endproperty
  a_launch: assert property (p_launch) else $error("Output moved without launch edge");
  property p_read_only; $rose(o_dq_oe) |-> rd_pend; endproperty
  a_read_only: assert property (p_read_only) else $error("Bus driven without read load");
  property p_four_max; o_dq_oe |-> n_lr <= 3'h4; endproperty
  a_four_max: assert property (p_four_max) else $error("Burst longer than four beats");
  property p_end_burst; n_lr == 3'h4 |-> ##[0:6] !o_dq_oe; endproperty
  a_end_burst: assert property (p_end_burst) else $error("Burst not ended");
  property p_oe_hold; $rose(o_dq_oe) |=> o_dq_oe [*2]; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("Burst dropped early");
  property p_idle_quiet; !o_dq_oe && !$past(o_dq_oe) |-> $stable(o_dq); endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("Data moved while idle");
  c_read: cover property ($rose(o_dq_oe));
  c_stop: cover property (n_stop == 4'hf && o_dq_oe);
  c_chi: cover property (chi && $rose(o_dq_oe));
endmodule // srb_sram_core_asserts

bind srb_sram_core srb_sram_core_asserts #(.DW(DW)) i_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_clk_in_true(i_clk_in_true),
  .i_clk_in_inv(i_clk_in_inv), .i_clk_out_true(i_clk_out_true),
  .i_clk_out_inv(i_clk_out_inv), .i_load_strobe_n(i_load_strobe_n),
  .i_read_not_write(i_read_not_write), .o_dq(o_dq), .o_dq_oe(o_dq_oe));
`default_nettype wire

// file: dv/test_srb_sram_core.sv
/* Bench for the burst SRAM core at x36 width, with an x8 copy on the same pins.
   Both copies use a six-bit address.
   Assumes the controller model drives every link pin on i_mclk rises. */
`timescale 1ns/10ps
`default_nettype none
// ****************
// Bench top
// ****************
module test_srb_sram_core;
  logic                c = 1'b0;
  logic                r = 1'b1;
  logic                kt, kn, ct, cn, ld_n, rnw, oe;
  logic [5:0]          a;
  logic [3:0]          be_n;
  logic [35:0]         d, q;
  logic [7:0]          q8;
  logic                oe8;
  int                  failures = 0;
  int                  n_checks = 0;
  int                  cyc = 0;
  wire [35:0]          d_in = oe ? q : d;
  wire [7:0]           d_in8 = oe8 ? q8 : d[7:0];
  localparam [143:0]   wrd = {36'hcdef01234, 36'h3456789ab, 36'habcdef012, 36'h123456789};
  localparam [143:0]   msk = {36'hff803fe00, 36'h007fc01ff, 36'h0, 36'hfffffffff};
  srb_ctrl_model i_ctrl (
    .i_mclk(c), .i_q(q), .i_oe(oe), .o_kt(kt), .o_kn(kn), .o_ct(ct), .o_cn(cn),
    .o_ld_n(ld_n), .o_rnw(rnw), .o_addr(a), .o_bwe_n(be_n), .o_d(d));
  srb_sram_core #(.AW(6), .DW(36)) i_dut (
    .i_mclk(c), .i_rst(r), .i_clk_in_true(kt), .i_clk_in_inv(kn),
    .i_clk_out_true(ct), .i_clk_out_inv(cn), .i_load_strobe_n(ld_n),
    .i_read_not_write(rnw), .i_burst_addr_bit0(a[0]), .i_burst_addr_bit1(a[1]),
    .i_addr_hi(a[5:2]), .i_byte_wr_en_n(be_n), .i_nibble_wr_en0_n(1'b1),
    .i_nibble_wr_en1_n(1'b1), .i_dq(d_in), .o_dq(q), .o_dq_oe(oe));
  // The x8 copy shares every link pin; its nibble enables follow the low byte enables.
  srb_sram_core #(.AW(6), .DW(8)) i_dut_x8 (
    .i_mclk(c), .i_rst(r), .i_clk_in_true(kt), .i_clk_in_inv(kn),
    .i_clk_out_true(ct), .i_clk_out_inv(cn), .i_load_strobe_n(ld_n),
    .i_read_not_write(rnw), .i_burst_addr_bit0(a[0]), .i_burst_addr_bit1(a[1]),
    .i_addr_hi(a[5:2]), .i_byte_wr_en_n(4'hf), .i_nibble_wr_en0_n(be_n[0]),
    .i_nibble_wr_en1_n(be_n[1]), .i_dq(d_in8), .o_dq(q8), .o_dq_oe(oe8));
  always #50 c = ~c;
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Beat k of a read is sampled in half k+2; the bus drops in half six.
  task automatic rd_chk(input logic [5:0] ad, input logic [143:0] e, input logic chi,
                        input int pause);
    i_ctrl.frame(1'b1, 1'b1, ad, 144'h0, 16'h0, chi, pause);
    for (int i = 0; i < 4; i++) check(i_ctrl.rq[i+2], e[i*36 +: 36]);
    for (int h = 0; h < 7; h++) check({35'h0, i_ctrl.roe[h]}, {35'h0, h >= 2 && h <= 5});
  endtask
  task automatic t_reset;
    check(q, 36'h0);
    check({35'h0, oe}, 36'h0);
    check({35'h0, oe8}, 36'h0);
    $display("t_reset done");
  endtask
  task automatic t_wrap;
    i_ctrl.frame(1'b1, 1'b0, 6'h05, wrd, 16'h0, 1'b0, 9);
    rd_chk(6'h04, {wrd[107:0], wrd[143:108]}, 1'b0, 3);
    check(i_ctrl.p_q, wrd[35:0]);
    check({35'h0, i_ctrl.p_oe}, 36'h1);
    rd_chk(6'h07, {wrd[71:0], wrd[143:72]}, 1'b0, 9);
    rd_chk(6'h06, {wrd[35:0], wrd[143:36]}, 1'b1, 9);
    $display("t_wrap done");
  endtask
  task automatic t_mask;
    i_ctrl.frame(1'b1, 1'b0, 6'h08, 144'h0, 16'h0, 1'b0, 9);
    i_ctrl.frame(1'b1, 1'b0, 6'h08, {144{1'b1}}, 16'h5af0, 1'b0, 9);
    rd_chk(6'h08, msk, 1'b0, 9);
    check({28'h0, q8}, 36'hf0);
    check({35'h0, oe8}, 36'h0);
    $display("t_mask done");
  endtask
  task automatic t_nop;
    i_ctrl.frame(1'b0, 1'b0, 6'h08, wrd, 16'h0, 1'b0, 9);
    for (int h = 0; h < 7; h++) check({35'h0, i_ctrl.roe[h]}, 36'h0);
    rd_chk(6'h08, msk, 1'b0, 9);
    check({28'h0, q8}, 36'hf0);
    $display("t_nop done");
  endtask
  // The whole run is a few hundred cycles, so only a hang reaches this ceiling.
  always @(posedge c) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    repeat (20) @(posedge c);
    r <= 1'b0;
    repeat (5) @(posedge c);
    t_reset();
    t_wrap();
    t_mask();
    t_nop();
    close_out();
  end
endmodule // test_srb_sram_core
`default_nettype wire

// file: hw/srb_sram_core.v
/*
  Burst-of-four common-I/O DDR SRAM core with its write buffer FIFO.
  Assumes every link clock and pin is asynchronous to i_mclk and much
  slower than it; all of them are sampled through two flip-flops here.
*/
`timescale 1ns/10ps
`default_nettype none
`include "srb_defines.vh"

// ****************************************************************
// Write buffer FIFO
// ****************************************************************
module srb_fifo #(
  parameter W     = 8,
  parameter DEPTH = `SRB_FIFO_DEPTH
) (
  // Clock and reset
  input  wire         i_mclk,
  input  wire         i_rst,
  // Fill side
  input  wire         i_valid,
  output wire         o_ready,
  input  wire [W-1:0] i_data,
  // Drain side
  output wire         o_valid,
  input  wire         i_ready,
  output wire [W-1:0] o_data
);
  localparam PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam integer  LAST_I = DEPTH - 1;
  localparam integer  FULL_I = DEPTH;
  localparam [PW-1:0] LAST   = LAST_I[PW-1:0];
  localparam [PW:0]   FULL   = FULL_I[PW:0];

  // ****************************************************************
  // Storage and pointers
  // ****************************************************************
  reg [W-1:0]  mem_reg [0:DEPTH-1];
  reg [PW-1:0] wr_ptr_reg;
  reg [PW-1:0] rd_ptr_reg;
  reg [PW:0]   count_reg;

  wire push = i_valid & o_ready;
  wire pop  = o_valid & i_ready;

  // ****************************************************************
  // Handshake flags
  // ****************************************************************
  // The fill count is one bit wider than the pointers so that full and empty differ.
  assign o_ready = (count_reg != FULL);
  assign o_valid = (count_reg != {(PW+1){1'b0}});
  assign o_data  = mem_reg[rd_ptr_reg];

  always @(posedge i_mclk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_data;
    end
  end

  // ****************************************************************
  // Pointer and count update
  // ****************************************************************
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_reg <= {PW{1'b0}};
      rd_ptr_reg <= {PW{1'b0}};
      count_reg  <= {(PW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST) ? {PW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST) ? {PW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // srb_fifo

// Functional notes
// - x18/x36 bursts step the two low address bits by a wrapping increment.
// - Every transaction ends by itself after four data beats.
// - Command decode runs only on input true clock rises; burst beats also step on other clock rises.
// - Load low, write direction at true rise starts write; four beats alternate clocks.
// - Load low, read direction at true rise returns four beats on output clocks.
// - With all four link clocks stopped the data outputs keep their last state.
// - Write data is sampled on rises of both input clocks.
// - Read data launches on output clock rises, or input clocks if both held high.
// - Load and direction are registered only on the true input clock rise.
// - Data outputs stay high impedance from power-up and reset.
// - x18 byte enables zero and one gate bits 0-8 and 9-17.
// - All write enables high leaves that beat's memory word unchanged.
// - Write enables are applied as sampled with each individual beat.
// - Write enables matter only for beats of an initiated write.
// - x36 byte enables two and three gate bits 18-26 and 27-35.
// - x8 nibble enables gate bits 0-3 and 4-7.
// - The two low address inputs are the burst start word on x18/x36.
// - Load low defines a transaction of four words over two clock periods.
module srb_sram_core #(
  parameter AW = `SRB_ADDR_W,
  parameter DW = `SRB_DW_X18
) (
  // Core clock and reset
  input  wire          i_mclk,
  input  wire          i_rst,
  // Link clocks
  input  wire          i_clk_in_true,
  input  wire          i_clk_in_inv,
  input  wire          i_clk_out_true,
  input  wire          i_clk_out_inv,
  // Command and address
  input  wire          i_load_strobe_n,
  input  wire          i_read_not_write,
  input  wire          i_burst_addr_bit0,
  input  wire          i_burst_addr_bit1,
  input  wire [AW-3:0] i_addr_hi,
  // Write masks
  input  wire [3:0]    i_byte_wr_en_n,
  input  wire          i_nibble_wr_en0_n,
  input  wire          i_nibble_wr_en1_n,
  // Data bus
  input  wire [DW-1:0] i_dq,
  output reg  [DW-1:0] o_dq,
  output reg           o_dq_oe
);
  localparam LW    = (DW == `SRB_DW_X8) ? `SRB_LANE_NIB : `SRB_LANE_BYTE;
  localparam NL    = DW / LW;
  localparam DEPTH = 1 << AW;
  localparam SW    = `SRB_NUM_CK + `SRB_NUM_CTL + AW + DW + `SRB_NUM_EN;
  localparam EW    = AW + `SRB_MASK_W + DW;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Everything goes through the same two stages so that clocks, commands
  // and data stay aligned to each other after sampling.
  // A pin change reaches the edge detectors two cycles later, so the link
  // must run far below i_mclk for every level to be seen around its edge.
  wire [SW-1:0] pins = {i_byte_wr_en_n,
                        i_nibble_wr_en1_n,
                        i_nibble_wr_en0_n,
                        i_dq,
                        i_addr_hi,
                        i_burst_addr_bit1,
                        i_burst_addr_bit0,
                        i_read_not_write,
                        i_load_strobe_n,
                        i_clk_out_inv,
                        i_clk_out_true,
                        i_clk_in_inv,
                        i_clk_in_true};
  reg  [SW-1:0] s1_reg;
  reg  [SW-1:0] s2_reg;
  reg  [`SRB_NUM_CK-1:0] ck_d_reg;

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s1_reg   <= {SW{1'b0}};
      s2_reg   <= {SW{1'b0}};
      ck_d_reg <= {`SRB_NUM_CK{1'b0}};
    end else begin
      s1_reg   <= pins;
      s2_reg   <= s1_reg;
      ck_d_reg <= s2_reg[`SRB_NUM_CK-1:0];
    end
  end

  wire [`SRB_NUM_CK-1:0] ck = s2_reg[`SRB_NUM_CK-1:0];
  wire          ld_n    = s2_reg[`SRB_NUM_CK];
  wire          rnw     = s2_reg[`SRB_NUM_CK+1];
  wire [AW-1:0] addr    = s2_reg[`SRB_NUM_CK+`SRB_NUM_CTL +: AW];
  wire [DW-1:0] dq_s    = s2_reg[`SRB_NUM_CK+`SRB_NUM_CTL+AW +: DW];
  wire [1:0]    nib_n   = s2_reg[`SRB_NUM_CK+`SRB_NUM_CTL+AW+DW +: 2];
  wire [3:0]    byte_n  = s2_reg[`SRB_NUM_CK+`SRB_NUM_CTL+AW+DW+2 +: 4];

  // ****************************************************************
  // Clock edge detection
  // ****************************************************************
  wire [`SRB_NUM_CK-1:0] rise = ck & ~ck_d_reg;
  wire k_rise    = rise[`SRB_CK_IN_T];
  wire kn_rise   = rise[`SRB_CK_IN_N];

  // ****************************************************************
  // Launch clock selection
  // ****************************************************************
  // The choice is made at every edge, so the mode may change between bursts
  // without a stray launch as long as both output clocks move together.
  wire c_held    = ck[`SRB_CK_OUT_T] & ck[`SRB_CK_OUT_N];
  wire launch_p  = c_held ? k_rise  : rise[`SRB_CK_OUT_T];
  wire launch_n  = c_held ? kn_rise : rise[`SRB_CK_OUT_N];

  // ****************************************************************
  // Command decode
  // ****************************************************************
  reg          wr_act_reg;
  reg  [1:0]   wr_cnt_reg;
  reg  [1:0]   wr_lo_reg;
  reg  [AW-3:0] wr_hi_reg;
  reg          rd_act_reg;
  reg  [1:0]   rd_cnt_reg;
  reg  [1:0]   rd_lo_reg;
  reg  [AW-3:0] rd_hi_reg;

  // A burst must drain before a new load is looked at; loads in between
  // are ignored as the controller is expected to space them out.
  wire cmd_ok   = k_rise & ~wr_act_reg & ~rd_act_reg;
  wire wr_start = cmd_ok & ~ld_n & ~rnw;
  wire rd_start = cmd_ok & ~ld_n & rnw;
  // x8 parts have no random start word, so their bursts begin aligned.
  wire [1:0] start_lo = (DW == `SRB_DW_X8) ? `SRB_BEAT_FIRST : addr[1:0];

  // ****************************************************************
  // Write beat capture
  // ****************************************************************
  wire wr_beat = wr_start | (wr_act_reg & ((kn_rise & wr_cnt_reg[0]) |
                                           (k_rise & ~wr_cnt_reg[0])));
  wire [1:0]    beat_idx = wr_start ? `SRB_BEAT_FIRST : wr_cnt_reg;
  wire [1:0]    beat_lo  = (wr_start ? start_lo : wr_lo_reg) + beat_idx;
  wire [AW-3:0] beat_hi  = wr_start ? addr[AW-1:2] : wr_hi_reg;

  reg [`SRB_MASK_W-1:0] beat_mask;
  always @* begin
    beat_mask = {`SRB_MASK_W{1'b0}};
    if (DW == `SRB_DW_X8) begin
      beat_mask[1:0] = ~nib_n;
    end else begin
      beat_mask[NL-1:0] = ~byte_n[NL-1:0];
    end
  end

  reg [EW-1:0] cap_reg;
  reg          cap_vld_reg;
  wire         fifo_in_rdy;

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wr_act_reg  <= 1'b0;
      wr_cnt_reg  <= `SRB_BEAT_FIRST;
      wr_lo_reg   <= 2'h0;
      wr_hi_reg   <= {(AW-2){1'b0}};
      cap_reg     <= {EW{1'b0}};
      cap_vld_reg <= 1'b0;
    end else begin
      if (cap_vld_reg && fifo_in_rdy) begin
        cap_vld_reg <= 1'b0;
      end
      if (wr_start) begin
        wr_lo_reg <= start_lo;
        wr_hi_reg <= addr[AW-1:2];
      end
      if (wr_beat) begin
        // Each beat carries its own sampled mask.
        // The buffer never fills at link speed, so no stall path is kept here.
        cap_reg     <= {beat_hi, beat_lo, beat_mask, dq_s};
        cap_vld_reg <= 1'b1;
        wr_cnt_reg  <= beat_idx + `SRB_BEAT_STEP;
        wr_act_reg  <= (beat_idx != `SRB_BEAT_LAST);
      end
    end
  end

  // ****************************************************************
  // Write buffer and memory array
  // ****************************************************************
  wire          f_vld;
  wire [EW-1:0] f_data;
  wire          rd_beat;
  // The array has one port per lane; a write waits out any read launch.
  wire          drain_rdy = ~rd_beat;
  wire          drain     = f_vld & drain_rdy;
  wire [AW-1:0] drain_addr = f_data[EW-1 -: AW];
  wire [`SRB_MASK_W-1:0] drain_mask = f_data[DW +: `SRB_MASK_W];
  wire [AW-1:0] rd_addr   = {rd_hi_reg, rd_lo_reg + rd_cnt_reg};
  wire [DW-1:0] rd_word;

  srb_fifo #(
    .W     (EW),
    .DEPTH (`SRB_FIFO_DEPTH)
  ) u_wr_fifo (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_valid (cap_vld_reg),
    .o_ready (fifo_in_rdy),
    .i_data  (cap_reg),
    .o_valid (f_vld),
    .i_ready (drain_rdy),
    .o_data  (f_data)
  );

  genvar l;
  generate
    for (l = 0; l < NL; l = l + 1) begin : g_lane
      reg [LW-1:0] lane_mem [0:DEPTH-1];
      always @(posedge i_mclk) begin
        if (drain && drain_mask[l]) begin
          lane_mem[drain_addr] <= f_data[l*LW +: LW];
        end
      end
      assign rd_word[l*LW +: LW] = lane_mem[rd_addr];
    end
  endgenerate

  // ****************************************************************
  // Read burst launch
  // ****************************************************************
  // The word is looked up in the launch cycle itself, so a write still
  // waiting in the buffer for that address is not yet visible to a read.
  assign rd_beat = rd_act_reg & ((launch_n & ~rd_cnt_reg[0]) |
                                 (launch_p & rd_cnt_reg[0]));

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rd_act_reg <= 1'b0;
      rd_cnt_reg <= `SRB_BEAT_FIRST;
      rd_lo_reg  <= 2'h0;
      rd_hi_reg  <= {(AW-2){1'b0}};
      o_dq       <= {DW{1'b0}};
      o_dq_oe    <= 1'b0;
    end else begin
      if (rd_start) begin
        rd_act_reg <= 1'b1;
        rd_cnt_reg <= `SRB_BEAT_FIRST;
        rd_lo_reg  <= start_lo;
        rd_hi_reg  <= addr[AW-1:2];
      end
      if (rd_beat) begin
        o_dq       <= rd_word;
        o_dq_oe    <= 1'b1;
        rd_cnt_reg <= rd_cnt_reg + `SRB_BEAT_STEP;
        rd_act_reg <= (rd_cnt_reg != `SRB_BEAT_LAST);
      end else if (launch_p || launch_n) begin
        // With no edges at all the bus simply keeps its state.
        o_dq_oe <= 1'b0;
      end
    end
  end
endmodule // srb_sram_core
`default_nettype wire

// file: inc/srb_defines.vh
/*
  Shared constants of the burst SRAM core: burst counts, lane widths, FIFO
  depth and the bit positions of the sampled pin vector.
  Assumes it is included once per compilation unit by its bare name.
*/
`ifndef SRB_DEFINES_VH
`define SRB_DEFINES_VH

// ****************************************************************
// Burst sequencing
// ****************************************************************
`define SRB_BEAT_FIRST  2'h0
`define SRB_BEAT_LAST   2'h3
`define SRB_BEAT_STEP   2'h1

// ****************************************************************
// Data and address widths and write-mask lanes
// ****************************************************************
`define SRB_DW_X8       8
`define SRB_DW_X18      18
`define SRB_LANE_NIB    4
`define SRB_LANE_BYTE   9
`define SRB_MASK_W      4
`define SRB_ADDR_W      20

// ****************************************************************
// Write buffering
// ****************************************************************
`define SRB_FIFO_DEPTH  8

// ****************************************************************
// Clock bits and field widths of the sampled pin vector
// ****************************************************************
`define SRB_CK_IN_T     0
`define SRB_CK_IN_N     1
`define SRB_CK_OUT_T    2
`define SRB_CK_OUT_N    3
`define SRB_NUM_CK      4
`define SRB_NUM_CTL     2
`define SRB_NUM_EN      6

`endif
